// *** include/sdc_pkg.sv ***
// sdc_pkg: constants and types of the card command decoder
`default_nettype none
package sdc_pkg;
  // frame layout, msb first
  localparam int unsigned FRAME_BITS   = 48;
  localparam int unsigned FR_START_POS = 47;
  localparam int unsigned FR_TX_POS    = 46;
  localparam int unsigned FR_IDX_HI    = 45;
  localparam int unsigned FR_IDX_LO    = 40;
  localparam int unsigned FR_ARG_HI    = 39;
  localparam int unsigned FR_ARG_LO    = 8;
  localparam int unsigned FR_END_POS   = 0;
  localparam logic [5:0]  LAST_BIT_CNT = 6'h2F;
  localparam logic [5:0]  FIRST_BIT_CNT = 6'h01;
  localparam int unsigned SYNC_PINS    = 3;

  // command indices
  localparam logic [5:0] CMD_RESET     = 6'h00;
  localparam logic [5:0] CMD_INIT      = 6'h01;
  localparam logic [5:0] CMD_SWITCH    = 6'h06;
  localparam logic [5:0] CMD_RD_CSD    = 6'h09;
  localparam logic [5:0] CMD_RD_ID     = 6'h0A;
  localparam logic [5:0] CMD_STOP      = 6'h0C;
  localparam logic [5:0] CMD_STATUS    = 6'h0D;
  localparam logic [5:0] CMD_SET_BLEN  = 6'h10;
  localparam logic [5:0] CMD_RD_ONE    = 6'h11;
  localparam logic [5:0] CMD_RD_MULTI  = 6'h12;
  localparam logic [5:0] CMD_WR_ONE    = 6'h18;
  localparam logic [5:0] CMD_WR_MULTI  = 6'h19;
  localparam logic [5:0] CMD_PROG_CSD  = 6'h1B;
  localparam logic [5:0] CMD_SET_WP    = 6'h1C;

  // one bit per index
  localparam logic [63:0] SUPPORTED_MASK = 64'h0000_0000_1B07_3643;
  localparam logic [63:0] LOCKED_OK_MASK = 64'h0000_0000_0001_3603;
  localparam logic [63:0] RESERVED_MASK  = 64'h0000_0000_00E8_4120;

  // physical block and protection groups
  localparam int unsigned PHYS_SHIFT     = 9;
  localparam logic [32:0] PHYS_BLK_BYTES = 33'h0_0000_0200;
  localparam int unsigned WP_GRP_SHIFT   = 20;
  localparam int unsigned WP_GROUPS      = 16;
  localparam int unsigned WP_SEL_BITS    = 4;
  localparam int unsigned SWITCH_MODE_POS = 31;
  localparam int unsigned CSD_PROG_BITS  = 8;
  localparam int unsigned FUNC_SEL_BITS  = 4;

  // reset values
  localparam logic [31:0] BLEN_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    RESP_R1  = 2'b00,
    RESP_R1B = 2'b01,
    RESP_R2  = 2'b10
  } sdc_resp_type;

  typedef enum logic [3:0] {
    OP_REJECT    = 4'h0,
    OP_RESET     = 4'h1,
    OP_INIT      = 4'h2,
    OP_SW_CHECK  = 4'h3,
    OP_SW_SET    = 4'h4,
    OP_READ_CARD_SPECIFIC_COMMAND  = 4'h5,
    OP_SEND_ID   = 4'h6,
    OP_STOP      = 4'h7,
    OP_STATUS    = 4'h8,
    OP_SET_BLEN  = 4'h9,
    OP_RD_ONE    = 4'hA,
    OP_RD_MULTI  = 4'hB,
    OP_WR_ONE    = 4'hC,
    OP_WR_MULTI  = 4'hD,
    OP_PROG_CSD  = 4'hE,
    OP_SET_WP    = 4'hF
  } sdc_op_type;

  // word layout: arg, idx, op, resp, illegal, addr_err
  localparam int unsigned W_AERR   = 0;
  localparam int unsigned W_ILL    = 1;
  localparam int unsigned W_RESP_LO = 2;
  localparam int unsigned W_OP_LO  = 4;
  localparam int unsigned W_IDX_LO = 8;
  localparam int unsigned W_ARG_LO = 14;
  localparam int unsigned WORD_W   = 46;
endpackage
`default_nettype wire

// *** rtl/sdc_skid_buf.sv ***
// sdc_skid_buf: two-entry buffer whose head drives the output from a flop
`timescale 1ns/10ps
`default_nettype none
module sdc_skid_buf
  import sdc_pkg::*;
#(
  parameter int unsigned W = WORD_W
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic         head_v_ff;
  logic         tail_v_ff;
  logic [W-1:0] head_ff;
  logic [W-1:0] tail_ff;
  wire          push = in_valid & in_ready;
  wire          pop  = head_v_ff & out_ready;

  assign in_ready  = ~tail_v_ff;
  assign out_valid = head_v_ff;
  assign out_data  = head_ff;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      head_v_ff <= 1'b0;
      tail_v_ff <= 1'b0;
      head_ff   <= '0;
      tail_ff   <= '0;
    end else if (pop) begin
      // the tail moves up; a push can only land when the tail was free
      head_v_ff <= tail_v_ff | push;
      head_ff   <= tail_v_ff ? tail_ff : in_data;
      tail_v_ff <= 1'b0;
    end else if (push && !head_v_ff) begin
      head_v_ff <= 1'b1;
      head_ff   <= in_data;
    end else if (push) begin
      tail_v_ff <= 1'b1;
      tail_ff   <= in_data;
    end
  end
endmodule
`default_nettype wire

// *** rtl/sdc_cmd_decoder.sv ***
// sdc_cmd_decoder: serial command frame receiver and command decoder
//
// Operation
// - index field is the plain binary command number
// - execute only indices supported in this mode
// - reserved indices get no function at all
// - index 0 resets, index 1 starts init
// - index 6 checks (mode 0) or switches (mode 1)
// - index 9 and 10 return csd, id
// - index 18 streams blocks until index 12
// - index 13 returns status with two-byte response
// - index 16 argument sets later block length
// - default block length until host sets one
// - index 17 reads exactly one block
// - index 24 writes exactly one block
// - index 25 accepts blocks until stop token
// - block stays in physical block unless misalign allowed
// - index 28 sets protect bit of addressed group
// - always answer; unsupported index flagged illegal; a frame that arrives with the hand-off full is dropped
// - six-byte frame: 0, 1, index, arg, crc, 1
// - locked card rejects all but classes 0, 7
`timescale 1ns/10ps
`default_nettype none
module sdc_cmd_decoder
  import sdc_pkg::*;
(
  // clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  // serial link pins
  input  wire logic                       spi_sclk,
  input  wire logic                       spi_cs_n,
  input  wire logic                       spi_mosi,
  // decoded command stream
  output logic                            cmd_valid,
  input  wire logic                       cmd_ready,
  output logic [3:0]                      cmd_op,
  output logic [1:0]                      cmd_resp,
  output logic [5:0]                      cmd_index,
  output logic [31:0]                     cmd_arg,
  output logic                            cmd_illegal,
  output logic                            cmd_addr_err,
  // card conditions
  input  wire logic                       card_busy,
  input  wire logic                       card_locked,
  input  wire logic                       wp_supported,
  input  wire logic [31:0]                default_block_len,
  input  wire logic                       read_misalign_allowed,
  input  wire logic                       write_misalign_allowed,
  // data path events
  input  wire logic                       stop_token_seen,
  input  wire logic                       csd_prog_valid,
  input  wire logic [CSD_PROG_BITS-1:0]   csd_prog_data,
  // card state
  output logic                            card_idle_ff,
  output logic [31:0]                     block_len_ff,
  output logic                            multi_read_ff,
  output logic                            multi_write_ff,
  output logic [WP_GROUPS-1:0]            wp_bits_ff,
  output logic                            switch_mode_ff,
  output logic [FUNC_SEL_BITS-1:0]        func_sel_ff,
  output logic                            csd_prog_pend_ff,
  output logic [CSD_PROG_BITS-1:0]        csd_prog_ff,
  output logic                            overrun_ff
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [SYNC_PINS-1:0] sync1_ff;
  logic [SYNC_PINS-1:0] sync2_ff;
  wire  [SYNC_PINS-1:0] pins_raw = {spi_mosi, spi_cs_n, spi_sclk};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_PINS; gi++) begin : g_sync
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          sync1_ff[gi] <= 1'b1;
          sync2_ff[gi] <= 1'b1;
        end else begin
          sync1_ff[gi] <= pins_raw[gi];
          sync2_ff[gi] <= sync1_ff[gi];
        end
      end
    end
  endgenerate

  wire sclk_s = sync2_ff[0];
  wire cs_n_s = sync2_ff[1];
  wire mosi_s = sync2_ff[2];

  ////////////////////////////////////////////////////////////////////////////
  // frame receiver
  logic                  sclk_d_ff;
  logic                  in_frame_ff;
  logic [5:0]            bitcnt_ff;
  logic [FRAME_BITS-1:0] shift_ff;
  logic [FRAME_BITS-1:0] frame_ff;
  logic                  done_ff;

  wire sclk_rise  = sclk_s & ~sclk_d_ff;
  wire take_bit   = sclk_rise & ~cs_n_s;
  // a low bit while idle is the start bit; high bits are line fill
  wire frame_open = take_bit & ~in_frame_ff & ~mosi_s;
  wire frame_last = take_bit & in_frame_ff & (bitcnt_ff == LAST_BIT_CNT);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d_ff   <= 1'b1;
      in_frame_ff <= 1'b0;
      bitcnt_ff   <= '0;
      shift_ff    <= '0;
    end else begin
      sclk_d_ff <= sclk_s;
      if (cs_n_s || frame_last) begin
        in_frame_ff <= 1'b0;
      end else if (frame_open) begin
        in_frame_ff <= 1'b1;
        bitcnt_ff   <= FIRST_BIT_CNT;
        shift_ff    <= '0;
      end else if (take_bit && in_frame_ff) begin
        bitcnt_ff <= bitcnt_ff + 6'h01;
        shift_ff  <= {shift_ff[FRAME_BITS-2:0], mosi_s};
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_ff  <= 1'b0;
      frame_ff <= '0;
    end else begin
      done_ff <= frame_last;
      if (frame_last) begin
        frame_ff <= {shift_ff[FRAME_BITS-2:0], mosi_s};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command decode
  wire [5:0]  dec_idx = frame_ff[FR_IDX_HI:FR_IDX_LO];
  wire [31:0] dec_arg = frame_ff[FR_ARG_HI:FR_ARG_LO];
  // crc is not checked here; only the fixed framing bits
  wire frame_ok  = ~frame_ff[FR_START_POS] & frame_ff[FR_TX_POS] & frame_ff[FR_END_POS];
  wire supported = SUPPORTED_MASK[dec_idx];
  wire lock_ok   = LOCKED_OK_MASK[dec_idx];
  wire lock_rej  = card_locked & ~lock_ok;
  wire rd_rej    = multi_read_ff & (dec_idx != CMD_STOP);
  wire wp_rej    = (dec_idx == CMD_SET_WP) & ~wp_supported;

  // misalign check against the physical block
  wire        is_rd     = (dec_idx == CMD_RD_ONE) | (dec_idx == CMD_RD_MULTI);
  wire        is_wr     = (dec_idx == CMD_WR_ONE) | (dec_idx == CMD_WR_MULTI);
  wire [32:0] blk_off   = {24'h00_0000, dec_arg[PHYS_SHIFT-1:0]};
  wire [32:0] blk_end   = blk_off + {1'b0, block_len_ff};
  wire        crosses   = blk_end > PHYS_BLK_BYTES;
  wire        addr_err  = crosses & ((is_rd & ~read_misalign_allowed) |
                                     (is_wr & ~write_misalign_allowed));

  wire illegal = ~frame_ok | ~supported | lock_rej | rd_rej | wp_rej;
  wire reject  = illegal | addr_err | card_busy;
  wire accept  = done_ff & ~reject;

  function automatic sdc_op_type op_of(input logic [5:0] idx, input logic mode);
    unique case (idx)
      CMD_RESET:    op_of = OP_RESET;
      CMD_INIT:     op_of = OP_INIT;
      CMD_SWITCH:   op_of = mode ? OP_SW_SET : OP_SW_CHECK;
      CMD_RD_CSD:   op_of = OP_READ_CARD_SPECIFIC_COMMAND;
      CMD_RD_ID:    op_of = OP_SEND_ID;
      CMD_STOP:     op_of = OP_STOP;
      CMD_STATUS:   op_of = OP_STATUS;
      CMD_SET_BLEN: op_of = OP_SET_BLEN;
      CMD_RD_ONE:   op_of = OP_RD_ONE;
      CMD_RD_MULTI: op_of = OP_RD_MULTI;
      CMD_WR_ONE:   op_of = OP_WR_ONE;
      CMD_WR_MULTI: op_of = OP_WR_MULTI;
      CMD_PROG_CSD: op_of = OP_PROG_CSD;
      CMD_SET_WP:   op_of = OP_SET_WP;
      default:      op_of = OP_REJECT;
    endcase
  endfunction

  // busy answers stay r1 so the host always gets a reply
  wire sdc_op_type   dec_op   = reject ? OP_REJECT : op_of(dec_idx, dec_arg[SWITCH_MODE_POS]);
  wire sdc_resp_type dec_resp = reject ? RESP_R1 :
                                (dec_idx == CMD_STATUS) ? RESP_R2 :
                                ((dec_idx == CMD_STOP) | (dec_idx == CMD_SET_WP)) ? RESP_R1B :
                                RESP_R1;
  wire [WORD_W-1:0]  dec_word = {dec_arg, dec_idx, dec_op, dec_resp, illegal, addr_err};

  ////////////////////////////////////////////////////////////////////////////
  // answer hand-off and buffer
  logic              pend_v_ff;
  logic [WORD_W-1:0] pend_ff;
  logic              buf_ready;
  logic [WORD_W-1:0] buf_word;
  wire               pend_take = pend_v_ff & buf_ready;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_v_ff <= 1'b0;
      pend_ff   <= '0;
    end else if (done_ff && (!pend_v_ff || pend_take)) begin
      pend_v_ff <= 1'b1;
      pend_ff   <= dec_word;
    end else if (pend_take) begin
      pend_v_ff <= 1'b0;
    end
  end

  // a frame every 48 link clocks leaves ample time; a full stall drops the newest
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      overrun_ff <= 1'b0;
    end else if (done_ff && pend_v_ff && !pend_take) begin
      overrun_ff <= 1'b1;
    end else if (accept && dec_idx == CMD_RESET) begin
      overrun_ff <= 1'b0;
    end
  end

  sdc_skid_buf #(
    .W         (WORD_W)
  ) u_buf (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_valid  (pend_v_ff),
    .in_ready  (buf_ready),
    .in_data   (pend_ff),
    .out_valid (cmd_valid),
    .out_ready (cmd_ready),
    .out_data  (buf_word)
  );

  assign cmd_arg      = buf_word[W_ARG_LO +: 32];
  assign cmd_index    = buf_word[W_IDX_LO +: 6];
  assign cmd_op       = buf_word[W_OP_LO +: 4];
  assign cmd_resp     = buf_word[W_RESP_LO +: 2];
  assign cmd_illegal  = buf_word[W_ILL];
  assign cmd_addr_err = buf_word[W_AERR];

  ////////////////////////////////////////////////////////////////////////////
  // card state
  wire acc_reset = accept & (dec_idx == CMD_RESET);
  wire acc_blen  = accept & (dec_idx == CMD_SET_BLEN);
  logic        blen_set_ff;
  logic [31:0] blen_host_ff;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      card_idle_ff <= 1'b1;
      blen_set_ff  <= 1'b0;
      blen_host_ff <= BLEN_RST;
    end else begin
      if (acc_reset) begin
        card_idle_ff <= 1'b1;
        blen_set_ff  <= 1'b0;
      end else if (accept && dec_idx == CMD_INIT) begin
        card_idle_ff <= 1'b0;
      end
      if (acc_blen) begin
        blen_set_ff  <= 1'b1;
        blen_host_ff <= dec_arg;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      block_len_ff <= BLEN_RST;
    end else begin
      block_len_ff <= blen_set_ff ? blen_host_ff : default_block_len;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      multi_read_ff  <= 1'b0;
      multi_write_ff <= 1'b0;
    end else begin
      if (accept && dec_idx == CMD_RD_MULTI) begin
        multi_read_ff <= 1'b1;
      end else if (acc_reset || (accept && dec_idx == CMD_STOP)) begin
        multi_read_ff <= 1'b0;
      end
      // a new start wins over a stop token in the same cycle
      if (accept && dec_idx == CMD_WR_MULTI) begin
        multi_write_ff <= 1'b1;
      end else if (acc_reset || stop_token_seen) begin
        multi_write_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_bits_ff <= '0;
    end else if (accept && dec_idx == CMD_SET_WP) begin
      wp_bits_ff[dec_arg[WP_GRP_SHIFT +: WP_SEL_BITS]] <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      switch_mode_ff <= 1'b0;
      func_sel_ff    <= '0;
    end else if (accept && dec_idx == CMD_SWITCH) begin
      switch_mode_ff <= dec_arg[SWITCH_MODE_POS];
      if (dec_arg[SWITCH_MODE_POS]) begin
        func_sel_ff <= dec_arg[FUNC_SEL_BITS-1:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      csd_prog_pend_ff <= 1'b0;
      csd_prog_ff      <= '0;
    end else begin
      if (accept && dec_idx == CMD_PROG_CSD) begin
        csd_prog_pend_ff <= 1'b1;
      end else if (csd_prog_valid) begin
        csd_prog_pend_ff <= 1'b0;
      end
      if (csd_prog_pend_ff && csd_prog_valid) begin
        csd_prog_ff <= csd_prog_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  unsupported_flag_a: assert property (
    done_ff && !SUPPORTED_MASK[dec_idx] && !pend_v_ff |=> pend_v_ff && pend_ff[W_ILL]
  ) else $error("unsupported index not flagged");

  reserved_idx_a: assert property (
    done_ff && RESERVED_MASK[dec_idx] |-> dec_op == OP_REJECT
  ) else $error("reserved index got a function");

  always_answer_a: assert property (
    done_ff && !pend_v_ff |=> pend_v_ff && pend_ff[W_IDX_LO +: 6] == $past(dec_idx)
  ) else $error("frame got no answer");

  status_resp_a: assert property (
    accept && dec_idx == CMD_STATUS |-> dec_resp == RESP_R2
  ) else $error("status answer is not two-byte");

  blen_take_a: assert property (
    acc_blen |=> ##1 block_len_ff == $past(dec_arg, 2)
  ) else $error("block length not taken");

  blen_default_a: assert property (
    !blen_set_ff |=> block_len_ff == $past(default_block_len)
  ) else $error("default block length not used");

  read_stream_a: assert property (
    multi_read_ff && !(accept && (dec_idx == CMD_STOP || dec_idx == CMD_RESET)) |=> multi_read_ff
  ) else $error("multi read ended without stop");

  write_stop_a: assert property (
    multi_write_ff && stop_token_seen && !accept |=> !multi_write_ff
  ) else $error("stop token did not end writes");

  lock_reject_a: assert property (
    done_ff && card_locked && !LOCKED_OK_MASK[dec_idx] |-> !accept && dec_op == OP_REJECT
  ) else $error("locked card took a command");

  misalign_a: assert property (
    done_ff && is_rd && crosses && !read_misalign_allowed |-> !accept
  ) else $error("read crossed a block");

  wp_set_a: assert property (
    accept && dec_idx == CMD_SET_WP |=> wp_bits_ff[$past(dec_arg[WP_GRP_SHIFT +: WP_SEL_BITS])]
  ) else $error("protect bit not set");

  frame_bits_a: assert property (
    frame_last |=> done_ff && !frame_ff[FR_START_POS]
  ) else $error("frame closed at wrong bit");

endmodule
`default_nettype wire

// *** verif/sdc_host_model.sv ***
// sdc_host_model: behavioural link host that clocks command frames to the card
`timescale 1ns/10ps
`default_nettype none
module sdc_host_model (
  // link pins
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi
);
  // link clock stands low between frames
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one frame, msb first, 160 ns per bit
  task automatic send(input logic [47:0] fr);
    // small offset keeps pin changes off the core clock edges
    #3;
    spi_cs_n = 1'b0;
    #80;
    for (int b = 47; b >= 0; b--) begin
      spi_mosi = fr[b];
      #80 spi_sclk = 1'b1;
      #80 spi_sclk = 1'b0;
    end
    // released line flips so a stale bit never passes for data
    spi_mosi = ~fr[0];
    #80 spi_cs_n = 1'b1;
    #160;
  endtask
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
// tb_top: self-checking bench of the card command decoder
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import sdc_pkg::*;
  logic        core_clk, rst_n, cmd_ready, card_busy, card_locked, wp_supported;
  logic        rd_mis, wr_mis, stop_token_seen, csd_prog_valid;
  logic [31:0] dflt_len;
  logic [7:0]  csd_prog_data;
  wire         sclk, cs_n, mosi, cmd_valid, cmd_illegal, cmd_addr_err, card_idle_ff;
  wire         multi_read_ff, multi_write_ff, switch_mode_ff, csd_prog_pend_ff, overrun_ff;
  wire [3:0]   cmd_op, func_sel_ff;
  wire [1:0]   cmd_resp;
  wire [5:0]   cmd_index;
  wire [31:0]  cmd_arg, block_len_ff;
  wire [15:0]  wp_bits_ff;
  wire [7:0]   csd_prog_ff;
  int          errors, comparisons, cycles;

  sdc_host_model host (.spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi));
  sdc_cmd_decoder dut (.core_clk(core_clk), .rst_n(rst_n), .spi_sclk(sclk), .spi_cs_n(cs_n),
    .spi_mosi(mosi), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_resp(cmd_resp), .cmd_index(cmd_index), .cmd_arg(cmd_arg), .cmd_illegal(cmd_illegal),
    .cmd_addr_err(cmd_addr_err), .card_busy(card_busy), .card_locked(card_locked),
    .wp_supported(wp_supported), .default_block_len(dflt_len), .read_misalign_allowed(rd_mis),
    .write_misalign_allowed(wr_mis), .stop_token_seen(stop_token_seen),
    .csd_prog_valid(csd_prog_valid), .csd_prog_data(csd_prog_data), .card_idle_ff(card_idle_ff),
    .block_len_ff(block_len_ff), .multi_read_ff(multi_read_ff), .multi_write_ff(multi_write_ff),
    .wp_bits_ff(wp_bits_ff), .switch_mode_ff(switch_mode_ff), .func_sel_ff(func_sel_ff),
    .csd_prog_pend_ff(csd_prog_pend_ff), .csd_prog_ff(csd_prog_ff), .overrun_ff(overrun_ff));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic give_verdict();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [45:0] got, input logic [45:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ready is raised only after the word is read, so words wait in the buffer
  task automatic get_word(output logic [45:0] w);
    int n = 0;
    while (cmd_valid !== 1'b1 && n < 3000) begin
      @(negedge core_clk);
      n++;
    end
    chk(46'(cmd_valid), 46'h1);
    w = {cmd_arg, cmd_index, cmd_op, cmd_resp, cmd_illegal, cmd_addr_err};
    @(posedge core_clk) cmd_ready <= 1'b1;
    @(posedge core_clk) cmd_ready <= 1'b0;
    @(negedge core_clk);
  endtask

  task automatic cmd(input logic [5:0] i, input logic [31:0] a, input logic [7:0] e);
    logic [45:0] w;
    host.send({2'b01, i, a, 7'h00, 1'b1});
    get_word(w);
    chk(w, {a, i, e});
  endtask

  function automatic logic [7:0] exp_of(input logic [5:0] i, input logic [31:0] a);
    case (i)
      CMD_RESET: return {OP_RESET, RESP_R1, 2'b00};
      CMD_INIT: return {OP_INIT, RESP_R1, 2'b00};
      CMD_SWITCH: return {a[31] ? OP_SW_SET : OP_SW_CHECK, RESP_R1, 2'b00};
      CMD_RD_CSD: return {OP_READ_CARD_SPECIFIC_COMMAND, RESP_R1, 2'b00};
      CMD_RD_ID: return {OP_SEND_ID, RESP_R1, 2'b00};
      CMD_STOP: return {OP_STOP, RESP_R1B, 2'b00};
      CMD_STATUS: return {OP_STATUS, RESP_R2, 2'b00};
      CMD_SET_BLEN: return {OP_SET_BLEN, RESP_R1, 2'b00};
      CMD_RD_ONE: return {OP_RD_ONE, RESP_R1, 2'b00};
      CMD_RD_MULTI: return {OP_RD_MULTI, RESP_R1, 2'b00};
      CMD_WR_ONE: return {OP_WR_ONE, RESP_R1, 2'b00};
      CMD_WR_MULTI: return {OP_WR_MULTI, RESP_R1, 2'b00};
      CMD_PROG_CSD: return {OP_PROG_CSD, RESP_R1, 2'b00};
      CMD_SET_WP: return {OP_SET_WP, RESP_R1B, 2'b00};
      default: return {OP_REJECT, RESP_R1, 2'b10};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_table();
    int seq[$] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 13, 14, 15, 16, 17, 18, 12,
                   19, 20, 21, 22, 23, 24, 25, 26, 27, 28, 39};
    logic [31:0] a;
    foreach (seq[k]) begin
      a = (seq[k] == 16) ? 32'h0000_0100 : (seq[k] == 6) ? 32'h8000_0003 : 32'h0000_0000;
      if (seq[k] == 28) a = 32'h0030_0000;
      cmd(6'(seq[k]), a, exp_of(6'(seq[k]), a));
    end
    cmd(CMD_SWITCH, 32'h0000_0000, {OP_SW_CHECK, RESP_R1, 2'b00});
    chk(46'({card_idle_ff, switch_mode_ff, func_sel_ff}), 46'h03);
    chk(46'(block_len_ff), 46'h100);
    chk(46'(wp_bits_ff), 46'h0008);
    chk(46'({multi_read_ff, multi_write_ff, csd_prog_pend_ff}), 46'h3);
  endtask

  task automatic t_data_events();
    @(posedge core_clk) stop_token_seen <= 1'b1;
    @(posedge core_clk) stop_token_seen <= 1'b0;
    csd_prog_valid <= 1'b1;
    csd_prog_data <= 8'hA5;
    @(posedge core_clk) csd_prog_valid <= 1'b0;
    repeat (2) @(negedge core_clk);
    chk(46'({multi_write_ff, csd_prog_pend_ff, csd_prog_ff}), 46'h0A5);
  endtask

  task automatic t_misalign();
    cmd(CMD_RD_ONE, 32'h0000_0180, {OP_REJECT, RESP_R1, 2'b01});
    cmd(CMD_WR_ONE, 32'h0000_0180, {OP_REJECT, RESP_R1, 2'b01});
    cmd(CMD_RD_ONE, 32'h0000_0100, {OP_RD_ONE, RESP_R1, 2'b00});
    @(posedge core_clk) rd_mis <= 1'b1;
    cmd(CMD_WR_ONE, 32'h0000_0180, {OP_REJECT, RESP_R1, 2'b01});
    @(posedge core_clk) wr_mis <= 1'b1;
    cmd(CMD_RD_ONE, 32'h0000_0180, {OP_RD_ONE, RESP_R1, 2'b00});
    cmd(CMD_WR_ONE, 32'h0000_0180, {OP_WR_ONE, RESP_R1, 2'b00});
  endtask

  task automatic t_reject();
    logic [45:0] w;
    @(posedge core_clk) card_locked <= 1'b1;
    cmd(CMD_RD_ONE, 32'h0, {OP_REJECT, RESP_R1, 2'b10});
    cmd(CMD_STATUS, 32'h0, {OP_STATUS, RESP_R2, 2'b00});
    @(posedge core_clk) card_locked <= 1'b0;
    card_busy <= 1'b1;
    cmd(CMD_STATUS, 32'h0, {OP_REJECT, RESP_R1, 2'b00});
    @(posedge core_clk) card_busy <= 1'b0;
    cmd(CMD_RD_MULTI, 32'h0, {OP_RD_MULTI, RESP_R1, 2'b00});
    cmd(CMD_RD_ONE, 32'h0, {OP_REJECT, RESP_R1, 2'b10});
    cmd(CMD_STOP, 32'h0, {OP_STOP, RESP_R1B, 2'b00});
    chk(46'(multi_read_ff), 46'h0);
    @(posedge core_clk) wp_supported <= 1'b0;
    cmd(CMD_SET_WP, 32'h0050_0000, {OP_REJECT, RESP_R1, 2'b10});
    chk(46'(wp_bits_ff), 46'h0008);
    @(posedge core_clk) wp_supported <= 1'b1;
    host.send({2'b00, CMD_STATUS, 32'h0, 7'h00, 1'b1});
    get_word(w);
    chk(w, {32'h0, CMD_STATUS, OP_REJECT, RESP_R1, 2'b10});
  endtask

  // stall: two buffered, one held, the fourth is lost and flagged
  task automatic t_stall();
    logic [45:0] w;
    host.send({2'b01, CMD_STATUS, 32'h0, 7'h00, 1'b1});
    host.send({2'b01, CMD_RD_CSD, 32'h0, 7'h00, 1'b1});
    host.send({2'b01, CMD_RD_ID, 32'h0, 7'h00, 1'b1});
    host.send({2'b01, CMD_INIT, 32'h0, 7'h00, 1'b1});
    chk(46'(overrun_ff), 46'h1);
    get_word(w);
    chk(w, {32'h0, CMD_STATUS, OP_STATUS, RESP_R2, 2'b00});
    get_word(w);
    chk(w, {32'h0, CMD_RD_CSD, OP_READ_CARD_SPECIFIC_COMMAND, RESP_R1, 2'b00});
    get_word(w);
    chk(w, {32'h0, CMD_RD_ID, OP_SEND_ID, RESP_R1, 2'b00});
    cmd(CMD_RESET, 32'h0, {OP_RESET, RESP_R1, 2'b00});
    chk(46'({overrun_ff, card_idle_ff}), 46'h1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence and hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      errors++;
      give_verdict();
    end
  end

  initial begin
    {rst_n, cmd_ready, card_busy, card_locked, rd_mis, wr_mis} = '0;
    {stop_token_seen, csd_prog_valid, csd_prog_data} = '0;
    wp_supported = 1'b1;
    dflt_len = 32'h0000_0200;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (5) @(negedge core_clk);
    chk(46'({card_idle_ff, block_len_ff}), {13'h0, 1'b1, 32'h200});
    t_table();
    t_data_events();
    t_misalign();
    t_reject();
    t_stall();
    give_verdict();
  end
endmodule
`default_nettype wire
